// >>> fdel_core.sv
// Purpose: classify faults, keep status flags, escalate, pend handlers, track lockup
// Assumes: fault reports and context come from logic on the same clock
// Notes: status flags clear by writing one; a set in the same cycle wins

`timescale 1ns/100ps

module fdel_core #(
	parameter int ADDR_W = 8
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire fdel_pkg::fdel_fault_t i_fault,
	input wire logic i_ret_valid,
	input wire logic [31:0] i_ret_code,
	input wire fdel_pkg::fdel_ctx_t i_ctx,
	input wire logic [7:0] i_cur_prio,
	input wire logic i_entering_bus,
	input wire logic i_nmi,
	input wire logic i_dbg_halt,
	output fdel_pkg::fdel_pend_t o_pend,
	output logic o_lockup,
	output logic o_dbg_bus_err
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must be 6 to 32");
	end

	fdel_pkg::fdel_state_t s_r;
	fdel_pkg::fdel_state_t s_nxt;
	logic ret_bad;
	logic acc;
	logic wr;
	logic hit;
	logic [7:0] wa;
	logic [31:0] rd;
	logic ok;
	logic async;
	logic crit;
	logic esc;
	logic exempt;
	logic en_c;
	logic [7:0] prio_c;
	logic [2:0] cls;
	fdel_pkg::fdel_cause_t cause;
	logic [1:0] set_top;
	logic [7:0] set_prot;
	logic [7:0] set_bus;
	logic [5:0] set_use;
	logic [1:0] clr_top;
	logic [7:0] clr_prot;
	logic [7:0] clr_bus;
	logic [5:0] clr_use;

	fdel_ret_chk u_ret_chk (
		.i_valid(i_ret_valid),
		.i_code(i_ret_code),
		.o_bad(ret_bad)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.pend = '0;
		s_nxt.dbg_err = 1'b0;
		// apb: one wait state, write lands on the completing edge
		wa = 8'(i_paddr[ADDR_W-1:0] & {ADDR_W{1'b1}});
		acc = i_psel & i_penable;
		wr = acc & s_r.pready & i_pwrite;
		hit = 1'b1;
		case (wa)
			fdel_pkg::OFS_TOP: rd = {30'h0, s_r.top};
			fdel_pkg::OFS_PROT: rd = {24'h0, s_r.prot};
			fdel_pkg::OFS_BUS: rd = {24'h0, s_r.bus};
			fdel_pkg::OFS_USE: rd = {26'h0, s_r.usage};
			fdel_pkg::OFS_PADDR: rd = s_r.paddr;
			fdel_pkg::OFS_BADDR: rd = s_r.baddr;
			fdel_pkg::OFS_CTRL: rd = {29'h0, s_r.en};
			fdel_pkg::OFS_PRIO: rd = {8'h0, s_r.prio};
			fdel_pkg::OFS_STATE: rd = {30'h0, s_r.lock_nmi, s_r.lock};
			default: begin
				rd = 32'h0;
				hit = 1'b0;
			end
		endcase
		s_nxt.pready = acc & ~s_r.pready;
		if (acc & ~s_r.pready) begin
			s_nxt.prdata = i_pwrite ? 32'h0 : rd;
			s_nxt.pslverr = ~hit;
		end
		clr_top = (wr && wa == fdel_pkg::OFS_TOP) ? i_pwdata[1:0] : 2'h0;
		clr_prot = (wr && wa == fdel_pkg::OFS_PROT) ? i_pwdata[7:0] : 8'h0;
		clr_bus = (wr && wa == fdel_pkg::OFS_BUS) ? i_pwdata[7:0] : 8'h0;
		clr_use = (wr && wa == fdel_pkg::OFS_USE) ? i_pwdata[5:0] : 6'h0;
		if (wr && wa == fdel_pkg::OFS_CTRL) begin
			s_nxt.en = i_pwdata[2:0];
		end
		if (wr && wa == fdel_pkg::OFS_PRIO) begin
			s_nxt.prio = i_pwdata[23:0];
		end

		// classification; outside lockup a return-code error stands in when no non-debug fault is reported
		set_top = 2'h0;
		set_prot = 8'h0;
		set_bus = 8'h0;
		set_use = 6'h0;
		cls = 3'h0;
		cause = i_fault.cause;
		ok = i_fault.valid & ~i_fault.debug & ~s_r.lock;
		if (i_fault.valid && i_fault.debug) begin
			// debugger errors never touch exception state
			s_nxt.dbg_err = 1'b1;
		end
		if (ok) begin
			case (cause)
				fdel_pkg::C_VEC_READ: set_top[fdel_pkg::TOP_VEC] = 1'b1;
				fdel_pkg::C_PROT_INSTR, fdel_pkg::C_NEVER_EXEC: begin
					set_prot[fdel_pkg::PROT_INSTR] = 1'b1;
				end
				fdel_pkg::C_PROT_DATA: set_prot[fdel_pkg::PROT_DATA] = 1'b1;
				fdel_pkg::C_PROT_STK: set_prot[fdel_pkg::PROT_STK] = 1'b1;
				fdel_pkg::C_PROT_UNSTK: set_prot[fdel_pkg::PROT_UNSTK] = 1'b1;
				fdel_pkg::C_PROT_LSP: set_prot[fdel_pkg::PROT_LSP] = 1'b1;
				fdel_pkg::C_BUS_STK: set_bus[fdel_pkg::BUS_STK] = 1'b1;
				fdel_pkg::C_BUS_UNSTK: set_bus[fdel_pkg::BUS_UNSTK] = 1'b1;
				fdel_pkg::C_BUS_PREF: set_bus[fdel_pkg::BUS_PREF] = 1'b1;
				fdel_pkg::C_BUS_LSP: set_bus[fdel_pkg::BUS_LSP] = 1'b1;
				fdel_pkg::C_BUS_DATA: begin
					// stores go through the write buffer, so they report late
					set_bus[fdel_pkg::BUS_IMPREC] = i_fault.store;
					set_bus[fdel_pkg::BUS_PREC] = ~i_fault.store;
				end
				fdel_pkg::C_CACHE_MAINT: set_bus[fdel_pkg::BUS_PREC] = 1'b1;
				fdel_pkg::C_USE_COPROCESSOR_ABSENT_FLAG: set_use[fdel_pkg::USE_COPROCESSOR_ABSENT_FLAG] = 1'b1;
				fdel_pkg::C_USE_UNDEF: set_use[fdel_pkg::USE_UNDEF] = 1'b1;
				fdel_pkg::C_USE_INVST: set_use[fdel_pkg::USE_INVST] = 1'b1;
				fdel_pkg::C_USE_UNALN: set_use[fdel_pkg::USE_UNALN] = 1'b1;
				fdel_pkg::C_USE_DIVZ: set_use[fdel_pkg::USE_DIVZ] = 1'b1;
				default: set_use[fdel_pkg::USE_UNDEF] = 1'b1;
			endcase
		end else if (ret_bad && !s_r.lock) begin
			set_use[fdel_pkg::USE_INVALID_RETURN_CODE_FLAG] = 1'b1;
		end
		if (set_top != 2'h0) begin
			cls = 3'h1;
		end else if (set_prot != 8'h0) begin
			cls = 3'h2;
		end else if (set_bus != 8'h0) begin
			cls = 3'h3;
		end else if (set_use != 6'h0) begin
			cls = 3'h4;
		end
		case (cls)
			3'h2: begin
				en_c = s_r.en[fdel_pkg::EN_PROT];
				prio_c = s_r.prio[fdel_pkg::PRIO_PROT +: 8];
			end
			3'h3: begin
				en_c = s_r.en[fdel_pkg::EN_BUS];
				prio_c = s_r.prio[fdel_pkg::PRIO_BUS +: 8];
			end
			3'h4: begin
				en_c = s_r.en[fdel_pkg::EN_USE];
				prio_c = s_r.prio[fdel_pkg::PRIO_USE +: 8];
			end
			default: begin
				en_c = 1'b1;
				prio_c = 8'h0;
			end
		endcase
		async = set_bus[fdel_pkg::BUS_IMPREC];
		crit = (i_ctx == fdel_pkg::X_NMI) || (i_ctx == fdel_pkg::X_TOP);
		exempt = (cls == 3'h3) && set_bus[fdel_pkg::BUS_STK] && i_entering_bus;
		esc = ~en_c
			| ((i_ctx != fdel_pkg::X_THREAD) && (prio_c >= i_cur_prio))
			| ((cls == 3'h2) && (i_ctx == fdel_pkg::X_PROT))
			| ((cls == 3'h3) && (i_ctx == fdel_pkg::X_BUS))
			| ((cls == 3'h4) && (i_ctx == fdel_pkg::X_USE));

		// lockup release first, so a fresh entry below takes the last word
		if (s_r.lock && (i_dbg_halt || (i_nmi && !s_r.lock_nmi))) begin
			s_nxt.lock = 1'b0;
			s_nxt.lock_nmi = 1'b0;
		end
		if (cls != 3'h0) begin
			if (async) begin
				// pended whatever runs now; the store may belong to an earlier context
				s_nxt.pend.bus = s_r.en[fdel_pkg::EN_BUS];
				s_nxt.pend.top = ~s_r.en[fdel_pkg::EN_BUS];
				set_top[fdel_pkg::TOP_FORCED] = ~s_r.en[fdel_pkg::EN_BUS];
			end else if (crit) begin
				s_nxt.lock = 1'b1;
				s_nxt.lock_nmi = (i_ctx == fdel_pkg::X_NMI);
			end else if (cls == 3'h1) begin
				// top level outranks every configurable handler, no priority gate
				s_nxt.pend.top = 1'b1;
			end else if (esc && !exempt) begin
				s_nxt.pend.top = 1'b1;
				set_top[fdel_pkg::TOP_FORCED] = 1'b1;
			end else begin
				s_nxt.pend.prot = (cls == 3'h2);
				s_nxt.pend.bus = (cls == 3'h3);
				s_nxt.pend.usage = (cls == 3'h4);
			end
		end

		// address capture: only while not already holding one
		if (set_prot != 8'h0 && !s_r.prot[fdel_pkg::ADDR_VALID]) begin
			s_nxt.paddr = i_fault.addr;
			set_prot[fdel_pkg::ADDR_VALID] = 1'b1;
		end
		if (set_bus != 8'h0 && !async && !s_r.bus[fdel_pkg::ADDR_VALID]) begin
			s_nxt.baddr = i_fault.addr;
			set_bus[fdel_pkg::ADDR_VALID] = 1'b1;
		end

		// sticky flags, set beats clear
		s_nxt.top = (s_r.top & ~clr_top) | set_top;
		s_nxt.prot = ((s_r.prot & ~clr_prot) | set_prot) & 8'h9f;
		s_nxt.bus = ((s_r.bus & ~clr_bus) | set_bus) & 8'hbf;
		s_nxt.usage = (s_r.usage & ~clr_use) | set_use;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			s_r <= '0;
			s_r.en <= fdel_pkg::CTRL_RST;
			s_r.prio <= fdel_pkg::PRIO_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_prdata = s_r.prdata;
	assign o_pready = s_r.pready;
	assign o_pslverr = s_r.pslverr;
	assign o_pend = s_r.pend;
	assign o_lockup = s_r.lock;
	assign o_dbg_bus_err = s_r.dbg_err;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_lockup_entry: assert property (
		i_fault.valid && !i_fault.debug && !s_r.lock && crit && !async
		|=> o_lockup ##1 (o_lockup || $past(i_dbg_halt) || $past(i_nmi)))
		else $error("sync fault in critical handler did not lock up");
	a_lockup_hold: assert property (
		o_lockup && !i_dbg_halt && !i_nmi |=> o_lockup)
		else $error("lockup left without a release event");
	a_nmi_self: assert property (
		o_lockup && s_r.lock_nmi && !i_dbg_halt |=> o_lockup)
		else $error("nmi released a lockup entered from nmi");
	a_async_nolock: assert property (
		ok && async && !o_lockup |=> !o_lockup && (o_pend.bus != o_pend.top))
		else $error("async bus error locked up or pended wrongly");
	a_disabled_esc: assert property (
		ok && !async && !crit && cls == 3'h3 && !s_r.en[fdel_pkg::EN_BUS] && !exempt
		|=> o_pend.top && !o_pend.bus && s_r.top[fdel_pkg::TOP_FORCED])
		else $error("fault with disabled handler not escalated");
	a_debug_only: assert property (
		i_fault.valid && i_fault.debug && !ret_bad && !wr
		|=> o_dbg_bus_err && o_pend == '0 && $stable(s_r.bus))
		else $error("debugger error leaked into exception state");
	a_addr_stable: assert property (
		s_r.bus[fdel_pkg::ADDR_VALID] ##1 s_r.bus[fdel_pkg::ADDR_VALID]
		|-> $stable(s_r.baddr))
		else $error("bus fault address changed while valid");
	a_flag_sticky: assert property (
		s_r.prot[fdel_pkg::PROT_DATA] && !wr |=> s_r.prot[fdel_pkg::PROT_DATA])
		else $error("protection flag dropped without a clear");
	a_vector_top: assert property (
		ok && cause == fdel_pkg::C_VEC_READ && !crit
		|=> o_pend.top && s_r.top[fdel_pkg::TOP_VEC] && !s_r.top[fdel_pkg::TOP_FORCED]
			|| $past(s_r.top[fdel_pkg::TOP_FORCED]))
		else $error("vector read error not sent to top-level fault");
	a_bad_return: assert property (
		!i_fault.valid && !o_lockup && i_ret_valid && i_ret_code[31:5] != fdel_pkg::RET_UPPER
		|=> s_r.usage[fdel_pkg::USE_INVALID_RETURN_CODE_FLAG])
		else $error("bad return code not flagged");
	a_apb_wait: assert property (
		i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
		else $error("apb ready not a single pulse after one wait");

endmodule : fdel_core

// >>> fdel_pkg.sv
// Purpose: shared constants and carriers of the fault detect, escalate and lockup block
// Assumes: 32-bit register bus, one register per aligned word
// Notes: numeric priority, lower value is more urgent

package fdel_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_TOP = 8'h00;
	localparam logic [7:0] OFS_PROT = 8'h04;
	localparam logic [7:0] OFS_BUS = 8'h08;
	localparam logic [7:0] OFS_USE = 8'h0c;
	localparam logic [7:0] OFS_PADDR = 8'h10;
	localparam logic [7:0] OFS_BADDR = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [7:0] OFS_PRIO = 8'h1c;
	localparam logic [7:0] OFS_STATE = 8'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TOP_VEC = 0;
	localparam int TOP_FORCED = 1;
	localparam int PROT_INSTR = 0;
	localparam int PROT_DATA = 1;
	localparam int PROT_STK = 2;
	localparam int PROT_UNSTK = 3;
	localparam int PROT_LSP = 4;
	localparam int BUS_STK = 0;
	localparam int BUS_UNSTK = 1;
	localparam int BUS_PREF = 2;
	localparam int BUS_LSP = 3;
	localparam int BUS_PREC = 4;
	localparam int BUS_IMPREC = 5;
	localparam int ADDR_VALID = 7;
	localparam int USE_COPROCESSOR_ABSENT_FLAG = 0;
	localparam int USE_UNDEF = 1;
	localparam int USE_INVST = 2;
	localparam int USE_INVALID_RETURN_CODE_FLAG = 3;
	localparam int USE_UNALN = 4;
	localparam int USE_DIVZ = 5;
	localparam int EN_PROT = 0;
	localparam int EN_BUS = 1;
	localparam int EN_USE = 2;
	localparam int PRIO_PROT = 0;
	localparam int PRIO_BUS = 8;
	localparam int PRIO_USE = 16;

	// ----------------------------------------------------------------
	// reset values and return codes
	// ----------------------------------------------------------------
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [23:0] PRIO_RST = 24'h000000;
	localparam logic [26:0] RET_UPPER = 27'h7ffffff;
	localparam logic [4:0] RET_H_STD = 5'h11;
	localparam logic [4:0] RET_T_MAIN = 5'h19;
	localparam logic [4:0] RET_T_PROC = 5'h1d;
	localparam logic [4:0] RET_H_FP = 5'h01;
	localparam logic [4:0] RET_T_MAIN_FP = 5'h09;
	localparam logic [4:0] RET_T_PROC_FP = 5'h0d;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		C_VEC_READ = 5'h00,
		C_PROT_INSTR = 5'h01,
		C_PROT_DATA = 5'h02,
		C_PROT_STK = 5'h03,
		C_PROT_UNSTK = 5'h04,
		C_PROT_LSP = 5'h05,
		C_NEVER_EXEC = 5'h06,
		C_BUS_STK = 5'h07,
		C_BUS_UNSTK = 5'h08,
		C_BUS_PREF = 5'h09,
		C_BUS_LSP = 5'h0a,
		C_BUS_DATA = 5'h0b,
		C_CACHE_MAINT = 5'h0c,
		C_USE_COPROCESSOR_ABSENT_FLAG = 5'h0d,
		C_USE_UNDEF = 5'h0e,
		C_USE_INVST = 5'h0f,
		C_USE_UNALN = 5'h10,
		C_USE_DIVZ = 5'h11
	} fdel_cause_t;

	typedef enum logic [2:0] {
		X_THREAD = 3'h0,
		X_NMI = 3'h1,
		X_TOP = 3'h2,
		X_PROT = 3'h3,
		X_BUS = 3'h4,
		X_USE = 3'h5,
		X_OTHER = 3'h6
	} fdel_ctx_t;

	typedef struct packed {
		logic valid;
		fdel_cause_t cause;
		logic [31:0] addr;
		logic debug;
		logic store;
	} fdel_fault_t;

	typedef struct packed {
		logic top;
		logic prot;
		logic bus;
		logic usage;
	} fdel_pend_t;

	typedef struct packed {
		logic [1:0] top;
		logic [7:0] prot;
		logic [7:0] bus;
		logic [5:0] usage;
		logic [31:0] paddr;
		logic [31:0] baddr;
		logic [2:0] en;
		logic [23:0] prio;
		logic lock;
		logic lock_nmi;
		fdel_pend_t pend;
		logic dbg_err;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fdel_state_t;

endpackage : fdel_pkg

// >>> fdel_ret_chk.sv
// Purpose: check a loaded exception return code against the defined encodings
// Assumes: code arrives with its strobe from the pipeline on the core clock
// Notes: purely combinational

`timescale 1ns/100ps

module fdel_ret_chk (
	input wire logic i_valid,
	input wire logic [31:0] i_code,
	output logic o_bad
);

	logic low_ok;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		case (i_code[4:0])
			fdel_pkg::RET_H_STD, fdel_pkg::RET_T_MAIN, fdel_pkg::RET_T_PROC,
			fdel_pkg::RET_H_FP, fdel_pkg::RET_T_MAIN_FP, fdel_pkg::RET_T_PROC_FP: begin
				low_ok = 1'b1;
			end
			default: begin
				low_ok = 1'b0;
			end
		endcase
		// upper bits must all be one as well
		o_bad = i_valid & ~(low_ok & (i_code[31:5] == fdel_pkg::RET_UPPER));
	end

endmodule : fdel_ret_chk

// >>> fdel_pipe_model.sv
// Purpose: pipeline side model issuing fault reports and return codes
// Assumes: the bench requests one cycle ahead of the report
// Notes: idle address and code lines toggle so stale values are never trusted

`timescale 1ns/100ps

module fdel_pipe_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire fdel_pkg::fdel_fault_t i_rep,
	input wire logic i_ret_go,
	input wire logic [31:0] i_ret_code,
	output fdel_pkg::fdel_fault_t o_fault,
	output logic o_ret_valid,
	output logic [31:0] o_ret_code
);
	// ----------------------------------------------------------------
	// one-cycle reports
	// ----------------------------------------------------------------
	initial begin
		o_fault = '0;
		o_ret_valid = 1'b0;
		o_ret_code = 32'h0;
	end

	always @(posedge i_clk) begin
		if (i_go) begin
			o_fault <= i_rep;
		end else begin
			o_fault.valid <= 1'b0;
			o_fault.addr <= ~o_fault.addr;
		end
		o_ret_valid <= i_ret_go;
		o_ret_code <= i_ret_go ? i_ret_code : ~o_ret_code;
	end
endmodule : fdel_pipe_model

// >>> testbench.sv
// Purpose: self-checking bench of the fault detect, escalate and lockup block
// Assumes: apb answers within a few cycles; reports reach the core via the model
// Notes: pend pulses are gathered in a sticky mask so their exact cycle is not raced

`timescale 1ns/100ps

module testbench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, o_prdata, ret_code = 32'h0, s = 32'h37;
	logic o_pready, o_pslverr, go = 1'b0, ret_go = 1'b0, clr = 1'b0;
	logic entering = 1'b0, nmi = 1'b0, halt = 1'b0, o_lockup, o_dbg_bus_err, sdbg;
	logic [7:0] cur_prio = 8'hff;
	logic [3:0] seen;
	fdel_pkg::fdel_fault_t rep = '0, flt;
	fdel_pkg::fdel_ctx_t ctx = fdel_pkg::X_THREAD;
	fdel_pkg::fdel_pend_t o_pend;
	logic ret_v;
	logic [31:0] ret_c;
	int errors = 0, checked = 0;

	always #4 i_clk = ~i_clk;

	fdel_pipe_model u_fdel_pipe_model (.i_clk(i_clk), .i_go(go), .i_rep(rep),
		.i_ret_go(ret_go), .i_ret_code(ret_code), .o_fault(flt),
		.o_ret_valid(ret_v), .o_ret_code(ret_c));

	fdel_core #(.ADDR_W(8)) u_fdel_core (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_fault(flt), .i_ret_valid(ret_v), .i_ret_code(ret_c),
		.i_ctx(ctx), .i_cur_prio(cur_prio), .i_entering_bus(entering), .i_nmi(nmi),
		.i_dbg_halt(halt), .o_pend(o_pend), .o_lockup(o_lockup),
		.o_dbg_bus_err(o_dbg_bus_err));

	always @(posedge i_clk) begin
		seen <= clr ? 4'h0 : (seen | o_pend);
		sdbg <= clr ? 1'b0 : (sdbg | o_dbg_bus_err);
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : rnd

	// expected flag place, pend class and address register of a synchronous cause
	function automatic void exp_of(input fdel_pkg::fdel_cause_t c, output logic [7:0] o,
		output int b, output logic [3:0] k, output logic [7:0] ao);
		int i;
		i = int'(c);
		ao = 8'hff;
		if (c == fdel_pkg::C_VEC_READ) begin
			o = fdel_pkg::OFS_TOP;
			b = fdel_pkg::TOP_VEC;
			k = 4'h8;
		end else if (i <= 6) begin
			o = fdel_pkg::OFS_PROT;
			b = (i == 6) ? fdel_pkg::PROT_INSTR : i - 1;
			k = 4'h4;
			ao = fdel_pkg::OFS_PADDR;
		end else if (i <= 12) begin
			o = fdel_pkg::OFS_BUS;
			b = (i >= 11) ? fdel_pkg::BUS_PREC : i - 7;
			k = 4'h2;
			ao = fdel_pkg::OFS_BADDR;
		end else begin
			o = fdel_pkg::OFS_USE;
			b = (i >= 16) ? i - 12 : i - 13;
			k = 4'h1;
		end
	endfunction : exp_of

	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
		checked++;
		if (got !== want) begin
			errors++;
			$display("unexpected %0t %s got %h want %h", $time, m, got, want);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge i_clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (o_pready !== 1'b1) chk(1'b0, 1'b1, "apb hang");
		q = o_prdata;
		e = o_pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic send(input fdel_pkg::fdel_cause_t c, input logic [31:0] a,
		input logic st, input logic dbg, input logic rv);
		@(posedge i_clk);
		rep <= '{valid: 1'b1, cause: c, addr: a, debug: dbg, store: st};
		go <= ~rv;
		ret_go <= rv;
		ret_code <= a;
		clr <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
		ret_go <= 1'b0;
		clr <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask : send

	task automatic esc(input fdel_pkg::fdel_ctx_t x, input logic [7:0] p, input logic [2:0] en,
		input fdel_pkg::fdel_cause_t c, input logic st, input logic ent,
		input logic [3:0] ep, input logic ef, input logic el);
		logic [31:0] q;
		logic e;
		@(posedge i_clk);
		ctx <= x;
		cur_prio <= p;
		entering <= ent;
		apb(1'b1, fdel_pkg::OFS_CTRL, {29'h0, en}, q, e);
		send(c, rnd(), st, 1'b0, 1'b0);
		chk(seen, ep, "pend");
		apb(1'b0, fdel_pkg::OFS_TOP, 32'h0, q, e);
		chk(q[fdel_pkg::TOP_FORCED], ef, "forced");
		chk(o_lockup, el, "lockup");
		apb(1'b1, fdel_pkg::OFS_TOP, 32'h3, q, e);
	endtask : esc

	task automatic conclude();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge i_clk);
		chk(1'b0, 1'b1, "watchdog");
		conclude();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q, a, a0;
		logic e;
		logic [7:0] o, ao;
		int b;
		logic [3:0] k;
		logic [4:0] good [6];
		good = '{fdel_pkg::RET_H_STD, fdel_pkg::RET_T_MAIN, fdel_pkg::RET_T_PROC,
			fdel_pkg::RET_H_FP, fdel_pkg::RET_T_MAIN_FP, fdel_pkg::RET_T_PROC_FP};
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		for (int r = 0; r <= 8; r++) begin
			apb(1'b0, 8'(r * 4), 32'h0, q, e);
			chk(q, 32'h0, "reset value");
		end
		apb(1'b0, 8'h24, 32'h0, q, e);
		chk(q, 32'h0, "unmapped data");
		chk({31'h0, e}, 32'h1, "unmapped error");
		apb(1'b1, fdel_pkg::OFS_PRIO, 32'hff404040, q, e);
		apb(1'b0, fdel_pkg::OFS_PRIO, 32'h0, q, e);
		chk(q, 32'h00404040, "prio");
		apb(1'b1, fdel_pkg::OFS_CTRL, 32'h7, q, e);
		$display("test registers done");
		for (int i = 0; i < 18; i++) begin
			exp_of(fdel_pkg::fdel_cause_t'(i), o, b, k, ao);
			a = rnd();
			send(fdel_pkg::fdel_cause_t'(i), a, 1'b0, 1'b0, 1'b0);
			chk(seen, k, "class pend");
			apb(1'b0, o, 32'h0, q, e);
			chk(q[b], 1'b1, "cause flag");
			if (ao != 8'hff) begin
				apb(1'b0, ao, 32'h0, q, e);
				chk(q, a, "fault address");
			end
			apb(1'b1, o, 32'hff, q, e);
			apb(1'b0, o, 32'h0, q, e);
			chk(q, 32'h0, "flag clear");
		end
		a0 = rnd();
		send(fdel_pkg::C_PROT_DATA, a0, 1'b0, 1'b0, 1'b0);
		send(fdel_pkg::C_PROT_DATA, ~a0, 1'b0, 1'b0, 1'b0);
		apb(1'b1, fdel_pkg::OFS_PADDR, 32'h0, q, e);
		apb(1'b0, fdel_pkg::OFS_PADDR, 32'h0, q, e);
		chk(q, a0, "address kept");
		apb(1'b1, fdel_pkg::OFS_PROT, 32'hff, q, e);
		$display("test classes done");
		for (int i = 0; i < 6; i++) begin
			send(fdel_pkg::C_VEC_READ, {fdel_pkg::RET_UPPER, good[i]}, 1'b0, 1'b0, 1'b1);
			chk(seen, 4'h0, "good return");
		end
		send(fdel_pkg::C_VEC_READ, {fdel_pkg::RET_UPPER, 5'h15}, 1'b0, 1'b0, 1'b1);
		chk(seen, 4'h1, "bad low code");
		send(fdel_pkg::C_VEC_READ, {27'h3ffffff, fdel_pkg::RET_H_STD}, 1'b0, 1'b0, 1'b1);
		chk(seen, 4'h1, "bad upper bits");
		apb(1'b0, fdel_pkg::OFS_USE, 32'h0, q, e);
		chk(q[fdel_pkg::USE_INVALID_RETURN_CODE_FLAG], 1'b1, "return flag");
		apb(1'b1, fdel_pkg::OFS_USE, 32'hff, q, e);
		$display("test return codes done");
		esc(fdel_pkg::X_THREAD, 8'hff, 3'h0, fdel_pkg::C_USE_DIVZ, 0, 0, 4'h8, 1, 0);
		esc(fdel_pkg::X_THREAD, 8'hff, 3'h0, fdel_pkg::C_BUS_PREF, 0, 0, 4'h8, 1, 0);
		esc(fdel_pkg::X_OTHER, 8'h40, 3'h7, fdel_pkg::C_USE_UNDEF, 0, 0, 4'h8, 1, 0);
		esc(fdel_pkg::X_OTHER, 8'h41, 3'h7, fdel_pkg::C_USE_UNDEF, 0, 0, 4'h1, 0, 0);
		esc(fdel_pkg::X_USE, 8'h80, 3'h7, fdel_pkg::C_USE_UNDEF, 0, 0, 4'h8, 1, 0);
		esc(fdel_pkg::X_BUS, 8'h80, 3'h7, fdel_pkg::C_BUS_STK, 0, 1, 4'h2, 0, 0);
		esc(fdel_pkg::X_OTHER, 8'h00, 3'h7, fdel_pkg::C_BUS_DATA, 1, 0, 4'h2, 0, 0);
		apb(1'b0, fdel_pkg::OFS_BUS, 32'h0, q, e);
		chk(q[fdel_pkg::BUS_IMPREC], 1'b1, "imprecise");
		esc(fdel_pkg::X_TOP, 8'h80, 3'h0, fdel_pkg::C_BUS_DATA, 1, 0, 4'h8, 1, 0);
		esc(fdel_pkg::X_TOP, 8'h80, 3'h7, fdel_pkg::C_BUS_DATA, 0, 0, 4'h0, 0, 1);
		@(posedge i_clk);
		nmi <= 1'b1;
		@(posedge i_clk);
		nmi <= 1'b0;
		repeat (3) @(posedge i_clk);
		chk(o_lockup, 1'b0, "nmi release");
		esc(fdel_pkg::X_NMI, 8'h80, 3'h7, fdel_pkg::C_USE_UNDEF, 0, 0, 4'h0, 0, 1);
		apb(1'b0, fdel_pkg::OFS_STATE, 32'h0, q, e);
		chk(q, 32'h3, "lock from nmi");
		send(fdel_pkg::C_USE_DIVZ, rnd(), 1'b0, 1'b0, 1'b0);
		chk(seen, 4'h0, "ignored in lockup");
		@(posedge i_clk);
		nmi <= 1'b1;
		@(posedge i_clk);
		nmi <= 1'b0;
		repeat (3) @(posedge i_clk);
		chk(o_lockup, 1'b1, "nmi holds");
		halt <= 1'b1;
		repeat (3) @(posedge i_clk);
		halt <= 1'b0;
		chk(o_lockup, 1'b0, "halt release");
		ctx <= fdel_pkg::X_THREAD;
		send(fdel_pkg::C_BUS_DATA, rnd(), 1'b0, 1'b1, 1'b0);
		chk({sdbg, seen}, 5'h10, "debug error");
		$display("test escalation done");
		conclude();
	end
endmodule : testbench
